// file: rtl/fpsd_top.sv
// Design decision made here: the APB register port.
module fpsd_top
   import fpsd_pkg::*;
#(
   parameter int LOAD_CYCLES = FPSD_LOAD_CYCLES
)
(
   // clock and reset
   input  wire logic                   I_CLOCK,
   input  wire logic                   I_RESETN,
   // apb slave
   input  wire logic                   I_PSEL,
   input  wire logic                   I_PENABLE,
   input  wire logic                   I_PWRITE,
   input  wire logic [FPSD_ADDR_W-1:0] I_PADDR,
   input  wire logic [31:0]            I_PWDATA,
   output logic      [31:0]            O_PRDATA,
   output logic                        O_PREADY,
   output logic                        O_PSLVERR,
   // nonvolatile protection byte and flash controller status
   input  wire logic [7:0]             I_NVM_BYTE,
   input  wire logic                   I_BACKDOOR_OK,
   input  wire logic                   I_NORMAL_MODE,
   // decoded controls
   output logic                        O_LOADED,
   output logic                        O_SECURE,
   output logic                        O_BACKDOOR_UNLOCK_PERMIT,
   output logic                        O_BULK_ERASE_PERMIT,
   output logic                        O_FACTORY_ANALYSIS_ACCESS,
   output logic                        O_RESOURCE_RESTRICT
);
   logic        loaded;
   logic [7:0]  nvm_byte;
   logic [7:0]  status_r;
   logic        loaded_q_r;
   logic        unlock_r;
   logic [31:0] prdata_r;
   logic        slverr_r;
   logic        key_ok;
   logic        secure;
   logic        mass_ok;
   logic        fact_ok;
   logic        apb_acc;
   logic [5:0]  decode_word;

   function automatic logic field_is(input logic [1:0] f, input logic [1:0] v);
      return f == v;
   endfunction

   function automatic logic addr_mapped(input logic [FPSD_ADDR_W-1:0] a);
      return a == FPSD_STATUS_ADDR || a == FPSD_DECODE_ADDR || a == FPSD_CTRL_ADDR;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   fpsd_loader #(
      .LOAD_CYCLES (LOAD_CYCLES)
   ) u_loader (
      .i_clock    (I_CLOCK),
      .i_resetn   (I_RESETN),
      .i_nvm_byte (I_NVM_BYTE),
      .o_loaded   (loaded),
      .o_byte     (nvm_byte)
   );

   ////////////////////////////////////////////////////////////////////////////
   // status register: the load sets it once; the unlock overrides later
   always_ff @(posedge I_CLOCK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         status_r   <= FPSD_RESET_VALUE;
         loaded_q_r <= 1'b0;
      end
      else
      begin
         loaded_q_r <= loaded;
         if (loaded && !loaded_q_r)
            status_r <= nvm_byte;
         else if (loaded && unlock_r)
            status_r[FPSD_SEC_HI:FPSD_SEC_LO] <= FPSD_SEC_UNSECURE;
      end
   end

   // unlock event is only honoured when the stored key field allows it
   always_ff @(posedge I_CLOCK or negedge I_RESETN)
   begin
      if (!I_RESETN)
         unlock_r <= 1'b0;
      else
         unlock_r <= I_BACKDOOR_OK && key_ok && loaded_q_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode; until the status holds the stored byte everything reads as secure
   // and locked. gated by loaded_q_r, not the loader's flag, because status_r
   // still holds the reset value for one edge after the loader finishes
   assign key_ok  = loaded_q_r &&
                    field_is(status_r[FPSD_KEY_HI:FPSD_KEY_LO], FPSD_KEY_ENABLED);
   assign secure  = !loaded_q_r ||
                    !field_is(status_r[FPSD_SEC_HI:FPSD_SEC_LO], FPSD_SEC_UNSECURE);
   assign mass_ok = !field_is(status_r[FPSD_MASS_HI:FPSD_MASS_LO], FPSD_MASS_DISABLED);
   assign fact_ok = (status_r[FPSD_FACT_HI] == status_r[FPSD_FACT_LO]);

   assign O_LOADED                  = loaded_q_r;
   assign O_SECURE                  = secure;
   assign O_BACKDOOR_UNLOCK_PERMIT  = key_ok;
   // bulk erase only gated before the load, or while secure and outside normal mode
   assign O_BULK_ERASE_PERMIT       = loaded_q_r && (!secure || I_NORMAL_MODE || mass_ok);
   assign O_FACTORY_ANALYSIS_ACCESS = loaded_q_r && (!secure || fact_ok);
   assign O_RESOURCE_RESTRICT       = secure;
   assign decode_word = {O_RESOURCE_RESTRICT, O_FACTORY_ANALYSIS_ACCESS,
                         O_BULK_ERASE_PERMIT, O_BACKDOOR_UNLOCK_PERMIT,
                         O_SECURE, O_LOADED};

   ////////////////////////////////////////////////////////////////////////////
   // apb: zero wait states; all registers read-only, writes dropped
   assign apb_acc  = I_PSEL && I_PENABLE;
   assign O_PREADY = 1'b1;

   always_ff @(posedge I_CLOCK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         prdata_r <= 32'h0000_0000;
         slverr_r <= 1'b0;
      end
      else if (I_PSEL && !I_PENABLE)
      begin
         slverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         if (!I_PWRITE)
         begin
            case (I_PADDR)
               FPSD_STATUS_ADDR: prdata_r <= {24'h00_0000, status_r};
               FPSD_DECODE_ADDR: prdata_r <= {26'h000_0000, decode_word};
               FPSD_CTRL_ADDR:   prdata_r <= {31'h0000_0000, unlock_r};
               default:          slverr_r <= 1'b1;
            endcase
         end
         else if (!addr_mapped(I_PADDR))
            slverr_r <= 1'b1;
      end
   end

   assign O_PRDATA  = apb_acc ? prdata_r : 32'h0000_0000;
   assign O_PSLVERR = apb_acc && slverr_r;

   ////////////////////////////////////////////////////////////////////////////
   property load_once_p;
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      $rose(loaded) |=> (status_r == $past(nvm_byte));
   endproperty
   load_copy_a: assert property (load_once_p)
      else $error("status not loaded from stored byte");

   write_ignored_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      (apb_acc && I_PWRITE && loaded_q_r && !unlock_r) |=> $stable(status_r))
      else $error("write altered status");

   key_decode_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      O_BACKDOOR_UNLOCK_PERMIT |-> (loaded_q_r && status_r[7:6] == 2'b10))
      else $error("backdoor permit wrong");

   mass_decode_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      (loaded_q_r && secure && !I_NORMAL_MODE) |->
      (O_BULK_ERASE_PERMIT == (status_r[5:4] != 2'b10)))
      else $error("bulk erase decode wrong");

   mass_unsec_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      (loaded_q_r && !secure) |-> O_BULK_ERASE_PERMIT)
      else $error("bulk erase gated while unsecure");

   fact_decode_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      (loaded_q_r && secure) |->
      (O_FACTORY_ANALYSIS_ACCESS == (status_r[3:2] == 2'b00 || status_r[3:2] == 2'b11)))
      else $error("factory access decode wrong");

   sec_decode_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      loaded_q_r |-> (O_SECURE == (status_r[1:0] != 2'b10)))
      else $error("secure decode wrong");

   sequence unlock_seq;
      I_BACKDOOR_OK && key_ok && loaded_q_r;
   endsequence
   unlock_force_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      unlock_seq |-> ##2 (status_r[1:0] == 2'b10 && !O_SECURE))
      else $error("unlock did not force unsecure");

   restrict_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      O_RESOURCE_RESTRICT == O_SECURE)
      else $error("restriction not following secure state");

   ////////////////////////////////////////////////////////////////////////////
   // bus side and load window
   sequence status_setup_seq;
      I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == FPSD_STATUS_ADDR;
   endsequence

   sequence unmapped_setup_seq;
      I_PSEL && !I_PENABLE && I_PADDR != FPSD_STATUS_ADDR &&
      I_PADDR != FPSD_DECODE_ADDR && I_PADDR != FPSD_CTRL_ADDR;
   endsequence

   ready_tied_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      O_PREADY)
      else $error("ready not high");

   idle_rdata_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      !apb_acc |-> (O_PRDATA == 32'h0000_0000 && !O_PSLVERR))
      else $error("read data or error outside access phase");

   status_read_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      status_setup_seq |=> (prdata_r == {24'h00_0000, $past(status_r)}))
      else $error("status read returned wrong value");

   unmapped_err_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      unmapped_setup_seq |=> slverr_r)
      else $error("unmapped access gave no error");

   status_hold_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      (loaded_q_r && !unlock_r) |=> $stable(status_r))
      else $error("status changed without unlock");

   pre_load_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      !loaded_q_r |-> (O_SECURE && !O_BACKDOOR_UNLOCK_PERMIT && !O_BULK_ERASE_PERMIT
                      && !O_FACTORY_ANALYSIS_ACCESS))
      else $error("permission open before load");

   unlock_refused_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      (I_BACKDOOR_OK && !key_ok) |=> !unlock_r)
      else $error("unlock accepted without key permission");

   mass_normal_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      (loaded_q_r && I_NORMAL_MODE) |-> O_BULK_ERASE_PERMIT)
      else $error("bulk erase gated in normal mode");

   fact_unsec_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      (loaded_q_r && !secure) |-> O_FACTORY_ANALYSIS_ACCESS)
      else $error("factory access gated while unsecure");

   unlock_keeps_a: assert property (
      @(posedge I_CLOCK) disable iff (!I_RESETN)
      unlock_r |=> (status_r[7:2] == $past(status_r[7:2])))
      else $error("unlock disturbed other fields");
endmodule

// file: rtl/fpsd_pkg.sv
package fpsd_pkg;
   // register map (byte addresses, one aligned word each)
   localparam logic [7:0] FPSD_STATUS_OFS  = 8'h02;  // flash_protection_status index
   localparam logic [7:0] FPSD_STATUS_ADDR = 8'h08;  // index times four
   localparam logic [7:0] FPSD_CTRL_ADDR   = 8'h40;  // unlock pending flag
   localparam logic [7:0] FPSD_DECODE_ADDR = 8'h44;  // decoded permissions
   localparam int FPSD_ADDR_W = 8;
   // field positions
   localparam int FPSD_KEY_HI  = 7;
   localparam int FPSD_KEY_LO  = 6;
   localparam int FPSD_MASS_HI = 5;
   localparam int FPSD_MASS_LO = 4;
   localparam int FPSD_FACT_HI = 3;
   localparam int FPSD_FACT_LO = 2;
   localparam int FPSD_SEC_HI  = 1;
   localparam int FPSD_SEC_LO  = 0;
   // encodings
   localparam logic [1:0] FPSD_KEY_ENABLED   = 2'h2;
   localparam logic [1:0] FPSD_KEY_PREF_OFF  = 2'h1;
   localparam logic [1:0] FPSD_MASS_DISABLED = 2'h2;
   localparam logic [1:0] FPSD_SEC_UNSECURE  = 2'h2;
   // shipping value of the stored byte: unsecure, bulk erase and factory access open, backdoor key disabled
   localparam logic [7:0] FPSD_SHIP_BYTE     = 8'hFE;
   localparam logic [7:0] FPSD_RESET_VALUE   = 8'h00;
   // loader timing
   localparam int FPSD_LOAD_NS     = 40;
   localparam int FPSD_CLK_NS      = 4;
   localparam int FPSD_LOAD_CYCLES = (FPSD_LOAD_NS + FPSD_CLK_NS - 1) / FPSD_CLK_NS;
   typedef enum logic [1:0]
   {
      FPSD_IDLE = 2'b00,
      FPSD_WAIT = 2'b01,
      FPSD_DONE = 2'b10
   } fpsd_state_t;
endpackage

// file: rtl/fpsd_loader.sv
// fetches the protection byte after reset release; nvm port is same clock domain
module fpsd_loader
   import fpsd_pkg::*;
#(
   parameter int LOAD_CYCLES = FPSD_LOAD_CYCLES
)
(
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   input  wire logic [7:0] i_nvm_byte,
   output logic            o_loaded,
   output logic [7:0]      o_byte
);
   fpsd_state_t state_r;
   logic [7:0]  cnt_r;
   logic [7:0]  byte_r;

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_r <= FPSD_IDLE;
         cnt_r   <= 8'h00;
      end
      else
      begin
         case (state_r)
            FPSD_IDLE:
            begin
               state_r <= FPSD_WAIT;
               cnt_r   <= 8'(LOAD_CYCLES - 1);
            end
            FPSD_WAIT:
            begin
               if (cnt_r == 8'h00)
                  state_r <= FPSD_DONE;
               else
                  cnt_r <= cnt_r - 8'h01;
            end
            FPSD_DONE:
               state_r <= FPSD_DONE;
            default:
               state_r <= FPSD_IDLE;
         endcase
      end
   end

   // byte captured by a clocked process after release, never under reset
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
         byte_r <= FPSD_RESET_VALUE;
      else if (state_r == FPSD_WAIT && cnt_r == 8'h00)
         byte_r <= i_nvm_byte;
   end

   assign o_loaded = (state_r == FPSD_DONE);
   assign o_byte   = byte_r;
endmodule

// file: sim/fpsd_top_tb.sv
module fpsd_top_tb
   import fpsd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   ////////////////////////////////////////
   logic        clk = 0;
   logic        resetn = 0;
   logic        psel = 0;
   logic        pen = 0;
   logic        pwr = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwd = 32'hFFFF_FFFF;
   logic [7:0]  nvm = 8'h00;
   logic        bk = 0;
   logic        nm = 0;
   logic [31:0] rd;
   logic        err;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   wire  [5:0]  dec;
   int          fail_count = 0;
   int          checked = 0;
   int          cyc = 0;
   logic [7:0]  tbl [6] = '{FPSD_SHIP_BYTE, 8'h00, 8'h55, 8'hAA, 8'hFF, 8'hA1};
   logic [7:0]  unl [2] = '{8'hA0, 8'h60};

   fpsd_top #(.LOAD_CYCLES(2)) i_dut (
      .I_CLOCK(clk), .I_RESETN(resetn), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_NVM_BYTE(nvm),
      .I_BACKDOOR_OK(bk), .I_NORMAL_MODE(nm), .O_LOADED(dec[0]),
      .O_SECURE(dec[1]), .O_BACKDOOR_UNLOCK_PERMIT(dec[2]),
      .O_BULK_ERASE_PERMIT(dec[3]), .O_FACTORY_ANALYSIS_ACCESS(dec[4]),
      .O_RESOURCE_RESTRICT(dec[5]));

   initial
   begin
      forever #2 clk = ~clk;
   end

   // whole run is a few hundred cycles; this only cuts a hang
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         end_of_test;
      end
   end
   ////////////////////////////////////////
   task end_of_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one edge of gap first, so back-to-back calls never drive psel twice at once
   task apb(input logic w, input logic [7:0] a);
      @(posedge clk);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= a;
      @(posedge clk);
      pen <= 1;
      // no wait-state count is assumed; only the run's timeout ends a hang
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
   endtask

   task load(input logic [7:0] b);
      int n;
      @(posedge clk);
      resetn <= 0;
      nvm <= b;
      repeat (20) @(posedge clk);
      chk(32'(dec), 32'h0000_0022);
      resetn <= 1;
      n = 0;
      while (dec[0] !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      chk(32'(dec[0]), 32'h0000_0001);
      repeat (2) @(posedge clk);
   endtask

   function automatic logic [5:0] expd(input logic [7:0] b, input logic m);
      logic s;
      s = b[1:0] != FPSD_SEC_UNSECURE;
      expd = {s, !s || (b[3] == b[2]), !(s && !m && b[5:4] == FPSD_MASS_DISABLED),
              b[7:6] == FPSD_KEY_ENABLED, s, 1'b1};
   endfunction
   ////////////////////////////////////////
   initial
   begin
      foreach (tbl[i])
      begin
         load(tbl[i]);
         apb(0, FPSD_STATUS_ADDR);
         chk(rd, 32'(tbl[i]));
         chk(32'(err), 32'h0000_0000);
         for (int m = 0; m < 2; m++)
         begin
            nm <= m[0];
            apb(0, FPSD_DECODE_ADDR);
            chk(32'(dec), 32'(expd(tbl[i], m[0])));
            chk(rd, 32'(expd(tbl[i], m[0])));
         end
         $display("test decode %h done", tbl[i]);
      end
      // writes of all ones must leave the loaded byte alone
      apb(1, FPSD_STATUS_ADDR);
      chk(32'(err), 32'h0000_0000);
      apb(0, FPSD_STATUS_ADDR);
      chk(rd, 32'h0000_00A1);
      apb(0, 8'h10);
      chk(32'(err), 32'h0000_0001);
      $display("test write and unmapped done");
      foreach (unl[i])
      begin
         load(unl[i]);
         // key success held across a control read, so the pending flag is seen
         bk <= 1;
         apb(0, FPSD_CTRL_ADDR);
         chk(rd, 32'(unl[i][7:6] == FPSD_KEY_ENABLED));
         bk <= 0;
         repeat (3) @(posedge clk);
         apb(0, FPSD_STATUS_ADDR);
         if (unl[i][7:6] == FPSD_KEY_ENABLED)
            chk(rd, 32'({unl[i][7:2], FPSD_SEC_UNSECURE}));
         else
            chk(rd, 32'(unl[i]));
         chk(32'(dec[1]), 32'(unl[i][7:6] != FPSD_KEY_ENABLED));
         $display("test unlock %h done", unl[i]);
      end
      end_of_test;
   end
endmodule
